//--- verilog/flash_consts.svh
// timing constants for the flash link ends
`ifndef FLASH_CONSTS_SVH
`define FLASH_CONSTS_SVH

`define FL_CLK_NS 40
`define FL_LINK_NS 80
`define FL_PU_NS 300000
`define FL_RS_NS 50
`define FL_RPH_NS 35000
`define FL_RP_NS 200
`define FL_RH_NS 50
`define FL_CS_RD_NS 10
`define FL_CS_PE_NS 50

`define FL_CEIL(a, b) (((a) + (b) - 1) / (b))
`define FL_DEV_PU_CYC (`FL_PU_NS / `FL_LINK_NS)
`define FL_DEV_RPH_CYC `FL_CEIL(`FL_RPH_NS, `FL_LINK_NS)
`define FL_HOST_PU_CYC `FL_CEIL(`FL_PU_NS, `FL_CLK_NS)
`define FL_HOST_RPH_CYC `FL_CEIL(`FL_RPH_NS, `FL_CLK_NS)
`define FL_HOST_RP_CYC `FL_CEIL(`FL_RP_NS, `FL_CLK_NS)
`define FL_HOST_RH_CYC `FL_CEIL(`FL_RH_NS, `FL_CLK_NS)
`define FL_HOST_RS_CYC `FL_CEIL(`FL_RS_NS, `FL_CLK_NS)
`define FL_HOST_CSRD_CYC `FL_CEIL(`FL_CS_RD_NS, `FL_CLK_NS)
`define FL_HOST_CSPE_CYC `FL_CEIL(`FL_CS_PE_NS, `FL_CLK_NS)

`define FL_MHZ_READ 8'h32
`define FL_MHZ_SINGLE 8'h85
`define FL_MHZ_MULTI 8'h68
`define FL_MHZ_QPP 8'h50
`define FL_SCK_MHZ (1000 / `FL_LINK_NS)

`define FL_CNT_W 13
`define FL_LAST_BIT 3'h7

`endif

//--- verilog/flash_pkg.sv
// types shared by the flash link ends
package flash_pkg;

  typedef enum logic [2:0] {
    D_OFF   = 3'b000,
    D_COLD  = 3'b001,
    D_READY = 3'b011,
    D_WARM  = 3'b010,
    D_HELD  = 3'b111
  } dev_state_t;

  typedef enum logic [3:0] {
    H_PWR   = 4'b0000,
    H_PU    = 4'b0001,
    H_RHOLD = 4'b0011,
    H_IDLE  = 4'b0010,
    H_XFER  = 4'b0110,
    H_GAP   = 4'b0111,
    H_RLOW  = 4'b1011
  } host_state_t;

  typedef enum logic [2:0] {
    K_READ       = 3'b000,
    K_SINGLE     = 3'b001,
    K_MULTI_READ = 3'b010,
    K_QPP        = 3'b011,
    K_PROG_ERASE = 3'b100
  } cmd_kind_t;

  typedef struct packed {
    dev_state_t  state;
    logic [12:0] cnt;
    logic        sup_m;
    logic        sup_s;
    logic        flt_m;
    logic        flt_s;
    logic        rs_m;
    logic        rs_s;
    logic        rs_d;
    logic        por_bad;
    logic [7:0]  sh;
    logic [2:0]  bitn;
    logic [7:0]  rx_byte;
    logic        rx_valid;
    logic        so;
    logic        so_oe;
    logic        ready;
    logic        in_reset;
  } dev_regs_t;

  typedef struct packed {
    host_state_t state;
    logic [12:0] cnt;
    logic [1:0]  rs_age;
    logic        sup_m;
    logic        sup_s;
    logic        so_m;
    logic        so_s;
    logic        sck;
    logic        cs_n;
    logic        restart_n;
    logic        si;
    logic        rq_reset;
    logic        rq_cmd;
    cmd_kind_t   kind;
    logic [7:0]  tx;
    logic [7:0]  rx;
    logic [2:0]  bitn;
    logic [7:0]  rx_byte;
    logic        done;
    logic        refused;
    logic        ready;
  } host_regs_t;

endpackage : flash_pkg

//--- verilog/flash_link_if.sv
// serial link between host controller and flash device
`timescale 1ns/100ps
interface flash_link_if;
  logic sck;
  logic cs_n;
  logic restart_n;
  logic si;
  logic so;
  logic so_oe;
  logic so_line;

  // released line shows its pull-up level
  assign so_line = so_oe ? so : 1'b1;

  modport dev (
    input  sck,
    input  cs_n,
    input  restart_n,
    input  si,
    output so,
    output so_oe
  );

  modport host (
    output sck,
    output cs_n,
    output restart_n,
    output si,
    input  so,
    input  so_oe
  );
endinterface : flash_link_if

//--- verilog/flash_dev_end.sv
// flash device end: cold start, warm restart and serial standby
`timescale 1ns/100ps
`include "flash_consts.svh"
module flash_dev_end (
  flash_link_if.dev   link,
  input  wire logic   rst,
  input  wire logic   supply_ok,
  input  wire logic   por_fault,
  output logic        dev_ready,
  output logic        dev_in_reset,
  output logic [7:0]  rx_byte,
  output logic        rx_valid
);
  import flash_pkg::*;

  dev_regs_t s;
  dev_regs_t next_s;
  logic      fall;

  always_comb begin
    next_s = s;
    next_s.sup_m = supply_ok;
    next_s.sup_s = s.sup_m;
    next_s.flt_m = por_fault;
    next_s.flt_s = s.flt_m;
    next_s.rs_m = link.restart_n;
    next_s.rs_s = s.rs_m;
    next_s.rs_d = s.rs_s;
    next_s.rx_valid = 1'b0;
    next_s.so_oe = 1'b0;
    fall = s.rs_d & ~s.rs_s;
    case (s.state)
      D_OFF: begin
        next_s.cnt = '0;
        if (s.sup_s) begin
          next_s.state = D_COLD;
        end
      end
      D_COLD: begin
        next_s.cnt = s.cnt + 13'h0001;
        if (s.cnt == 13'(`FL_DEV_PU_CYC - 1)) begin
          next_s.por_bad = s.flt_s;
          next_s.cnt = '0;
          if (!s.rs_s) begin
            next_s.state = D_HELD;
          end else begin
            next_s.state = D_READY;
          end
        end
      end
      D_HELD: begin
        if (s.rs_s) begin
          next_s.state = D_READY;
        end
      end
      D_READY: begin
        if (fall) begin
          next_s.cnt = '0;
          next_s.bitn = '0;
          next_s.sh = '0;
          next_s.state = s.por_bad ? D_COLD : D_WARM;
        end else if (!link.cs_n) begin
          next_s.sh = {s.sh[6:0], link.si};
          next_s.bitn = s.bitn + 3'h1;
          next_s.so = link.si;
          next_s.so_oe = 1'b1;
          if (s.bitn == `FL_LAST_BIT) begin
            next_s.rx_byte = {s.sh[6:0], link.si};
            next_s.rx_valid = 1'b1;
          end
        end else begin
          next_s.bitn = '0;
        end
      end
      D_WARM: begin
        next_s.cnt = s.cnt + 13'h0001;
        if (s.cnt == 13'(`FL_DEV_RPH_CYC - 1)) begin
          next_s.state = D_READY;
          next_s.bitn = '0;
          next_s.cnt = '0;
        end
      end
      default: begin
        next_s.state = D_OFF;
      end
    endcase
    if (!s.sup_s && s.state != D_OFF) begin
      next_s.state = D_OFF;
      next_s.por_bad = 1'b0;
      next_s.so_oe = 1'b0;
    end
    next_s.ready = (next_s.state == D_READY);
    next_s.in_reset = (next_s.state != D_READY);
  end

  always_ff @(posedge link.sck or posedge rst) begin
    if (rst) begin
      s <= '{state: D_OFF, rs_m: 1'b1, rs_s: 1'b1, rs_d: 1'b1,
             in_reset: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign link.so = s.so;
  assign link.so_oe = s.so_oe;
  assign dev_ready = s.ready;
  assign dev_in_reset = s.in_reset;
  assign rx_byte = s.rx_byte;
  assign rx_valid = s.rx_valid;
endmodule : flash_dev_end

//--- verilog/flash_host_end.sv
// host end: power-up wait, warm restart pulses and byte transfers
`timescale 1ns/100ps
`include "flash_consts.svh"
module flash_host_end #(
  parameter int unsigned PU_CYC = `FL_HOST_PU_CYC
) (
  input  wire logic                clk,
  input  wire logic                rst,
  flash_link_if.host               link,
  input  wire logic                supply_up,
  input  wire logic                reset_req,
  input  wire logic                cmd_req,
  input  wire flash_pkg::cmd_kind_t cmd_kind,
  input  wire logic [7:0]          cmd_byte,
  output logic                     host_ready,
  output logic                     cmd_done,
  output logic                     cmd_refused,
  output logic [7:0]               rx_byte
);
  import flash_pkg::*;

  host_regs_t  s;
  host_regs_t  next_s;
  logic        tick;
  logic [12:0] gap;

  function automatic logic [7:0] max_mhz(input cmd_kind_t k);
    logic [7:0] m;
    m = `FL_MHZ_SINGLE;
    case (k)
      K_READ:       m = `FL_MHZ_READ;
      K_MULTI_READ: m = `FL_MHZ_MULTI;
      K_QPP:        m = `FL_MHZ_QPP;
      default:      m = `FL_MHZ_SINGLE;
    endcase
    return m;
  endfunction : max_mhz

  always_comb begin
    next_s = s;
    next_s.sup_m = supply_up;
    next_s.sup_s = s.sup_m;
    next_s.so_m = link.so_oe ? link.so : 1'b1;
    next_s.so_s = s.so_m;
    next_s.sck = ~s.sck;
    next_s.done = 1'b0;
    next_s.refused = 1'b0;
    tick = s.sck;
    gap = (s.kind == K_PROG_ERASE || s.kind == K_QPP)
          ? 13'(`FL_HOST_CSPE_CYC) : 13'(`FL_HOST_CSRD_CYC);
    if (reset_req) begin
      next_s.rq_reset = 1'b1;
    end
    if (cmd_req && !s.rq_cmd) begin
      next_s.rq_cmd = 1'b1;
      next_s.kind = cmd_kind;
      next_s.tx = cmd_byte;
    end
    if (s.restart_n && s.rs_age != 2'h3) begin
      next_s.rs_age = s.rs_age + 2'h1;
    end
    case (s.state)
      H_PWR: begin
        next_s.cs_n = 1'b1;
        next_s.restart_n = 1'b0;
        next_s.rs_age = '0;
        next_s.cnt = '0;
        if (s.sup_s && tick) begin
          next_s.state = H_PU;
        end
      end
      H_PU: begin
        next_s.cs_n = 1'b1;
        if (s.cnt < 13'(PU_CYC - 1)) begin
          next_s.cnt = s.cnt + 13'h0001;
        end else if (tick) begin
          next_s.restart_n = 1'b1;
          next_s.state = H_RHOLD;
          next_s.cnt = '0;
        end
      end
      H_RHOLD: begin
        next_s.cs_n = 1'b1;
        if (s.cnt < 13'(`FL_HOST_RH_CYC - 1)) begin
          next_s.cnt = s.cnt + 13'h0001;
        end else if (tick) begin
          next_s.state = H_IDLE;
          next_s.cnt = '0;
        end
      end
      H_IDLE: begin
        next_s.cs_n = 1'b1;
        if (tick && s.rq_reset
            && s.rs_age >= 2'(`FL_HOST_RS_CYC)) begin
          next_s.rq_reset = 1'b0;
          next_s.restart_n = 1'b0;
          next_s.rs_age = '0;
          next_s.cnt = '0;
          next_s.state = H_RLOW;
        end else if (tick && s.rq_cmd) begin
          next_s.rq_cmd = 1'b0;
          if (max_mhz(s.kind) < 8'(`FL_SCK_MHZ)) begin
            next_s.refused = 1'b1;
          end else begin
            next_s.cs_n = 1'b0;
            next_s.si = s.tx[7];
            next_s.tx = {s.tx[6:0], 1'b0};
            next_s.bitn = '0;
            next_s.state = H_XFER;
          end
        end
      end
      H_XFER: begin
        if (!tick) begin
          next_s.rx = {s.rx[6:0], s.so_s};
        end else if (s.bitn == `FL_LAST_BIT) begin
          next_s.cs_n = 1'b1;
          next_s.rx_byte = s.rx;
          next_s.done = 1'b1;
          next_s.cnt = '0;
          next_s.state = H_GAP;
        end else begin
          next_s.si = s.tx[7];
          next_s.tx = {s.tx[6:0], 1'b0};
          next_s.bitn = s.bitn + 3'h1;
        end
      end
      H_GAP: begin
        next_s.cs_n = 1'b1;
        if (s.cnt < gap - 13'h0001) begin
          next_s.cnt = s.cnt + 13'h0001;
        end else if (tick) begin
          next_s.state = H_IDLE;
          next_s.cnt = '0;
        end
      end
      H_RLOW: begin
        next_s.cs_n = 1'b1;
        if (s.cnt < 13'(`FL_HOST_RPH_CYC - `FL_HOST_RH_CYC - 1)
            || s.cnt < 13'(`FL_HOST_RP_CYC - 1)) begin
          next_s.cnt = s.cnt + 13'h0001;
        end else if (tick) begin
          next_s.restart_n = 1'b1;
          next_s.cnt = '0;
          next_s.state = H_RHOLD;
        end
      end
      default: begin
        next_s.state = H_PWR;
      end
    endcase
    if (!s.sup_s && s.state != H_PWR) begin
      next_s.state = H_PWR;
      next_s.cs_n = 1'b1;
      next_s.restart_n = 1'b0;
      next_s.rq_cmd = 1'b0;
      next_s.rq_reset = 1'b0;
    end
    next_s.ready = (next_s.state == H_IDLE);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '{state: H_PWR, kind: K_READ, cs_n: 1'b1, so_m: 1'b1, so_s: 1'b1,
             default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign link.sck = s.sck;
  assign link.cs_n = s.cs_n;
  assign link.restart_n = s.restart_n;
  assign link.si = s.si;
  assign host_ready = s.ready;
  assign cmd_done = s.done;
  assign cmd_refused = s.refused;
  assign rx_byte = s.rx_byte;
endmodule : flash_host_end

//--- verif/flash_link_checker.sv
// assertions on the link between the host and device ends
`timescale 1ns/100ps
module flash_link_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic restart_n,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe
);
  logic [15:0] low_cnt;
  logic [15:0] high_cnt;

  // clk cycles restart has stayed low or high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt  <= 16'h0000;
      high_cnt <= 16'h0000;
    end else begin
      low_cnt  <= restart_n ? 16'h0000 : low_cnt + 16'h0001;
      high_cnt <= restart_n ? high_cnt + 16'h0001 : 16'h0000;
    end
  end

  sel_in_reset_a: assert property (@(posedge clk) disable iff (rst)
    !restart_n |-> cs_n) else $error("select low while restart low");
  hold_after_a: assert property (@(posedge clk) disable iff (rst)
    $rose(restart_n) |-> cs_n [*2]) else $error("select too soon after restart");
  pulse_sum_a: assert property (@(posedge clk) disable iff (rst)
    $rose(restart_n) |-> low_cnt >= 16'h0369) else $error("restart pulse too short");
  setup_high_a: assert property (@(posedge clk) disable iff (rst)
    $fell(restart_n) |-> high_cnt >= 16'h0002) else $error("restart setup too short");
  sck_rate_a: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> sck != $past(sck)) else $error("link clock not clk over two");
  cs_gap_a: assert property (@(posedge clk) disable iff (rst)
    $rose(cs_n) |=> cs_n) else $error("select gap too short");
  oe_select_a: assert property (@(posedge sck) disable iff (rst)
    so_oe |-> !$past(cs_n)) else $error("device drives while not selected");
  echo_bit_a: assert property (@(posedge sck) disable iff (rst)
    so_oe |-> so == $past(si)) else $error("device output not last input bit");
  float_rst_a: assert property (@(posedge sck) disable iff (rst)
    !restart_n && !$past(restart_n, 4) |-> !so_oe) else $error("device drives in restart");

  cover property (@(posedge clk) $rose(restart_n) && low_cnt < 16'h0400);
  cover property (@(posedge clk) $rose(cs_n));
  cover property (@(posedge sck) so_oe && so);
endmodule : flash_link_checker

//--- verif/tb_top.sv
// bench: power-up, commands, warm and failed cold restarts
`timescale 1ns/100ps
module tb_top;
  import flash_pkg::*;
  logic       clk;
  logic       rst;
  logic       sup;
  logic       fault;
  logic       rreq;
  logic       creq;
  cmd_kind_t  kind;
  logic [7:0] cbyte;
  logic       hrdy;
  logic       done;
  logic       refd;
  logic       drdy;
  logic [7:0] drx;
  logic [7:0] hrx;
  logic       dinr;
  int         error_cnt;
  int         cmp_count;
  int         cyc;
  int         n;
  logic [7:0] corner [5] = '{8'h00, 8'hff, 8'ha5, 8'h5a, 8'h01};

  flash_link_if flash_link_if_inst ();
  flash_host_end flash_host_end_inst (.clk, .rst, .link(flash_link_if_inst),
    .supply_up(sup), .reset_req(rreq), .cmd_req(creq), .cmd_kind(kind),
    .cmd_byte(cbyte), .host_ready(hrdy), .cmd_done(done), .cmd_refused(refd),
    .rx_byte(hrx));
  flash_dev_end flash_dev_end_inst (.link(flash_link_if_inst), .rst,
    .supply_ok(sup), .por_fault(fault), .dev_ready(drdy), .dev_in_reset(dinr),
    .rx_byte(drx), .rx_valid());
  flash_link_checker flash_link_checker_inst (.clk, .rst,
    .sck(flash_link_if_inst.sck), .cs_n(flash_link_if_inst.cs_n),
    .restart_n(flash_link_if_inst.restart_n), .si(flash_link_if_inst.si),
    .so(flash_link_if_inst.so), .so_oe(flash_link_if_inst.so_oe));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // host sees the echo two link bits late, idle line high before it
  function automatic logic [7:0] exp_hrx(logic [7:0] b);
    return {2'b11, b[7:2]};
  endfunction : exp_hrx

  function automatic logic in_rng(int v, int lo, int hi);
    return v >= lo && v <= hi;
  endfunction : in_rng

  task automatic chk_f(logic got, logic exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t flag %b not %b", $time, got, exp);
    end
  endtask : chk_f

  task automatic chk_b(logic [7:0] got, logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t byte %h not %h", $time, got, exp);
    end
  endtask : chk_b

  task automatic wait_rdy(int lim);
    n = 0;
    while (!(hrdy === 1'b1 && drdy === 1'b1) && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_rdy

  task automatic pwr(logic f);
    rst   <= 1'b1;
    sup   <= 1'b0;
    fault <= f;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    sup <= 1'b1;
    repeat (7000) @(negedge clk);
    chk_f(drdy, 1'b0);
    chk_f(flash_link_if_inst.cs_n, 1'b1);
    wait_rdy(600);
    chk_f(in_rng(n, 499, 540), 1'b1);
    chk_f(dinr, 1'b0);
    @(posedge clk);
    fault <= 1'b0;
  endtask : pwr

  task automatic send(cmd_kind_t k, logic [7:0] b);
    logic r;
    r = 1'b0;
    @(posedge clk);
    creq  <= 1'b1;
    kind  <= k;
    cbyte <= b;
    @(posedge clk);
    creq <= 1'b0;
    for (int i = 0; i < 60 && done !== 1'b1; i++) begin
      @(negedge clk);
      r = r | refd;
    end
    chk_f(done, 1'b1);
    chk_f(r, 1'b0);
    chk_b(drx, b);
    chk_b(hrx, exp_hrx(b));
  endtask : send

  task automatic warm(int lo, int hi);
    @(posedge clk);
    rreq <= 1'b1;
    @(posedge clk);
    rreq <= 1'b0;
    for (int i = 0; i < 20 && flash_link_if_inst.restart_n !== 1'b0; i++) begin
      @(negedge clk);
    end
    chk_f(flash_link_if_inst.restart_n, 1'b0);
    repeat (20) @(negedge clk);
    chk_f(drdy, 1'b0);
    chk_f(dinr, 1'b1);
    wait_rdy(9000);
    chk_f(in_rng(n + 20, lo, hi), 1'b1);
  endtask : warm

  initial begin
    rst = 1'b1;
    sup = 1'b0;
    fault = 1'b0;
    rreq = 1'b0;
    creq = 1'b0;
    kind = K_READ;
    cbyte = 8'h00;
    error_cnt = 0;
    cmp_count = 0;
    cyc = 0;
    void'($urandom(6482));
    pwr(1'b0);
    $display("power-up test done");
    for (int i = 0; i < 12; i++) begin
      send(cmd_kind_t'(i < 5 ? i : $urandom_range(4)), i < 5 ? corner[i] : 8'($urandom));
    end
    $display("command test done");
    for (int j = 0; j < 3; j++) begin
      warm(875, 920);
      send(cmd_kind_t'($urandom_range(4)), 8'($urandom));
    end
    $display("warm restart test done");
    pwr(1'b1);
    warm(7500, 7560);
    send(K_MULTI_READ, 8'h96);
    $display("failed cold start test done");
    print_verdict();
  end
endmodule : tb_top
